// ### include/sre_pkg.sv
package sre_pkg;
	// ==========================================================
	// Clock and link timing
	localparam int CLK_MHZ      = 50;
	localparam int CK_HALF      = 4;
	localparam int NCK_CYC      = 2 * CK_HALF;
	localparam int TW           = 13;
	typedef logic [TW-1:0] sre_tmr_t;
	localparam int RFC1_NS      = 260;
	localparam int RFC2_NS      = 160;
	localparam int RFC4_NS      = 110;
	localparam int XS_MARGIN_NS = 10;
	localparam int XS_ABORT_NS  = 120;
	localparam int REFI_NS      = 7800;
	localparam int CKE_NCK      = 4;
	localparam int CKESR_NCK    = CKE_NCK + 1;
	localparam int CKSRE_NCK    = 8;
	localparam int CKSRX_NCK    = 8;
	localparam int XSDLL_NCK    = 512;
	localparam int MPX_LH_NCK   = 4;
	localparam int RFC1_CYC  = (RFC1_NS * CLK_MHZ + 999) / 1000;
	localparam int RFC2_CYC  = (RFC2_NS * CLK_MHZ + 999) / 1000;
	localparam int RFC4_CYC  = (RFC4_NS * CLK_MHZ + 999) / 1000;
	localparam int XS_CYC    =
		((RFC1_NS + XS_MARGIN_NS) * CLK_MHZ + 999) / 1000;
	localparam int XSF_CYC   =
		((RFC4_NS + XS_MARGIN_NS) * CLK_MHZ + 999) / 1000;
	localparam int XSA_CYC   = (XS_ABORT_NS * CLK_MHZ + 999) / 1000;
	localparam int REFI_CYC  = (REFI_NS * CLK_MHZ) / 1000;
	localparam int CKE_CYC   = CKE_NCK * NCK_CYC;
	localparam int CKESR_CYC = CKESR_NCK * NCK_CYC;
	localparam int CKSRE_CYC = CKSRE_NCK * NCK_CYC;
	localparam int CKSRX_CYC = CKSRX_NCK * NCK_CYC;
	localparam int XSDLL_CYC = XSDLL_NCK * NCK_CYC;
	localparam int MPXLH_CYC = MPX_LH_NCK * NCK_CYC;
	// ==========================================================
	// Refresh rates and modes
	localparam logic [1:0] RATE_1X = 2'h0;
	localparam logic [1:0] RATE_2X = 2'h1;
	localparam logic [1:0] RATE_4X = 2'h2;
	// ==========================================================
	// Controller registers
	localparam int AW = 4;
	localparam int DW = 16;
	localparam logic [AW-1:0] REG_CTRL   = 4'h0;
	localparam logic [AW-1:0] REG_CMD    = 4'h4;
	localparam logic [AW-1:0] REG_STATUS = 4'h8;
	localparam int CTRL_ENTER  = 0;
	localparam int CTRL_EXIT   = 1;
	localparam int CTRL_MODE   = 2;
	localparam int CTRL_ABORT  = 4;
	localparam int CTRL_VREF   = 5;
	localparam int CTRL_STOPCK = 6;
	localparam int CTRL_NOPX   = 7;
	localparam int CTRL_ODT    = 8;
	localparam logic [DW-1:0] CTRL_RW_MASK = 16'h01FC;
	localparam int CMD_REF     = 0;
	localparam int CMD_RATE    = 1;
	localparam int ST_SHORT    = 4;
	localparam int ST_CAL      = 5;
	localparam int ST_LOCKED   = 6;
	localparam int ST_WRITE    = 7;
	localparam int ST_REFDONE  = 3;
	localparam int ST_FINE     = 8;
	// ==========================================================
	// Link bit positions as sampled by the device
	localparam int LW      = 10;
	localparam int LK_CK   = 9;
	localparam int LK_CKE  = 8;
	localparam int LK_CS   = 7;
	localparam int LK_RAS  = 6;
	localparam int LK_CAS  = 5;
	localparam int LK_WE   = 4;
	localparam int LK_ACT  = 3;
	localparam int LK_ODT  = 2;
	// ==========================================================
	// States
	typedef enum logic [2:0] {
		CS_IDLE    = 3'h0,
		CS_SR      = 3'h1,
		CS_RESTART = 3'h2,
		CS_EXIT    = 3'h3,
		CS_MAKEUP  = 3'h4,
		CS_MKWAIT  = 3'h5
	} sre_ctl_state_t;
	typedef enum logic [0:0] {
		DS_NORMAL  = 1'h0,
		DS_SELFREF = 1'h1
	} sre_dev_state_t;
endpackage

// ### include/sre_link_if.sv
`timescale 1ns/1ps
interface sre_link_if;
	logic       ck;
	logic       cke;
	logic       csN;
	logic       rasN;
	logic       casN;
	logic       weN;
	logic       actN;
	logic       odt;
	logic [1:0] refRate;
	modport ctl (output ck, cke, csN, rasN, casN, weN, actN, odt, refRate);
	modport dev (input ck, cke, csN, rasN, casN, weN, actN, odt, refRate);
endinterface

// ### core/sre_device.sv
`timescale 1ns/1ps
module sre_device (
	input  wire logic clk,
	input  wire logic rst,
	sre_link_if.dev   link,
	input  wire logic dllCfgOn,
	input  wire logic abortEnable,
	input  wire logic vrefKeep,
	output logic      srActive,
	output logic      odtEnabled,
	output logic      dllEnabled,
	output logic      dllResetPulse,
	output logic      vrefPowered,
	output logic      refreshBusy,
	output logic [7:0] refreshCount
);
	// ==========================================================
	// Link sampling
	logic [sre_pkg::LW-1:0] meta_q;
	logic [sre_pkg::LW-1:0] sync_q;
	logic                   ckPrev_q;
	sre_pkg::sre_dev_state_t state_q;
	sre_pkg::sre_tmr_t      refTmr_q;
	sre_pkg::sre_tmr_t      busyTmr_q;
	logic ckRise;
	logic entryCmd;
	logic exitCmd;

	always_ff @(posedge clk) begin
		if (rst) begin
			meta_q   <= '0;
			sync_q   <= '0;
			ckPrev_q <= 1'b0;
		end else begin
			meta_q   <= {link.ck, link.cke, link.csN, link.rasN, link.casN,
			             link.weN, link.actN, link.odt, link.refRate};
			sync_q   <= meta_q;
			ckPrev_q <= sync_q[sre_pkg::LK_CK];
		end
	end

	assign ckRise = sync_q[sre_pkg::LK_CK] & ~ckPrev_q;
	assign entryCmd = ~sync_q[sre_pkg::LK_CS] & ~sync_q[sre_pkg::LK_RAS] &
	                  ~sync_q[sre_pkg::LK_CAS] & sync_q[sre_pkg::LK_WE] &
	                  sync_q[sre_pkg::LK_ACT] & ~sync_q[sre_pkg::LK_CKE];
	// exit on CKE high with deselect or NOP
	assign exitCmd = sync_q[sre_pkg::LK_CKE] & (sync_q[sre_pkg::LK_CS] |
	                 (sync_q[sre_pkg::LK_RAS] & sync_q[sre_pkg::LK_CAS] &
	                  sync_q[sre_pkg::LK_WE]));

	// ==========================================================
	// Mode state
	// only CK, CKE, CS, RAS, CAS and WE are looked at while in self refresh
	always_ff @(posedge clk) begin
		if (rst) begin
			state_q <= sre_pkg::DS_NORMAL;
		end else if (ckRise) begin
			unique case (state_q)
				sre_pkg::DS_NORMAL: begin
					if (entryCmd) begin
						state_q <= sre_pkg::DS_SELFREF;
					end
				end
				sre_pkg::DS_SELFREF: begin
					if (exitCmd) begin
						state_q <= sre_pkg::DS_NORMAL;
					end
				end
			endcase
		end
	end

	// termination off in self refresh; loop off, reset on exit
	// reference generator kept or dropped by mode bit
	always_ff @(posedge clk) begin
		if (rst) begin
			srActive      <= 1'b0;
			odtEnabled    <= 1'b1;
			dllEnabled    <= 1'b0;
			dllResetPulse <= 1'b0;
			vrefPowered   <= 1'b1;
		end else begin
			srActive      <= state_q == sre_pkg::DS_SELFREF;
			odtEnabled    <= state_q == sre_pkg::DS_NORMAL;
			dllEnabled    <= dllCfgOn & (state_q == sre_pkg::DS_NORMAL);
			dllResetPulse <= dllCfgOn & srActive &
			                 (state_q == sre_pkg::DS_NORMAL);
			vrefPowered   <= vrefKeep | (state_q == sre_pkg::DS_NORMAL);
		end
	end

	// ==========================================================
	// Internal refresh timer
	always_ff @(posedge clk) begin
		if (rst) begin
			refTmr_q     <= '0;
			busyTmr_q    <= '0;
			refreshBusy  <= 1'b0;
			refreshCount <= '0;
		end else if (state_q == sre_pkg::DS_NORMAL && ckRise && entryCmd) begin
			// first internal refresh well inside the CKE window
			refTmr_q <= sre_pkg::sre_tmr_t'(1);
		end else if (state_q == sre_pkg::DS_SELFREF && ckRise && exitCmd &&
		             abortEnable && refreshBusy) begin
			refreshBusy <= 1'b0;
			busyTmr_q   <= '0;
		end else begin
			if (state_q == sre_pkg::DS_SELFREF && refTmr_q != '0) begin
				refTmr_q <= refTmr_q - sre_pkg::sre_tmr_t'(1);
			end
			if (state_q == sre_pkg::DS_SELFREF &&
			    refTmr_q == sre_pkg::sre_tmr_t'(1) && !refreshBusy) begin
				refTmr_q    <= sre_pkg::sre_tmr_t'(sre_pkg::REFI_CYC);
				// each refresh takes the refresh cycle time
				busyTmr_q   <= sre_pkg::sre_tmr_t'(sre_pkg::RFC1_CYC);
				refreshBusy <= 1'b1;
			end else if (refreshBusy) begin
				if (busyTmr_q == sre_pkg::sre_tmr_t'(1)) begin
					refreshBusy  <= 1'b0;
					refreshCount <= refreshCount + 8'h01;
				end
				busyTmr_q <= busyTmr_q - sre_pkg::sre_tmr_t'(1);
			end
		end
	end
endmodule

// ### core/sre_controller.sv
`timescale 1ns/1ps
module sre_controller (
	input  wire logic                 clk,
	input  wire logic                 rst,
	sre_link_if.ctl                   link,
	input  wire logic [sre_pkg::AW-1:0] addr,
	input  wire logic [sre_pkg::DW-1:0] wrData,
	input  wire logic                 wrStb,
	input  wire logic                 rdStb,
	output logic [sre_pkg::DW-1:0]    rdData
);
	// ==========================================================
	// Declarations
	sre_pkg::sre_ctl_state_t state_q;
	logic [sre_pkg::DW-1:0] ctrl_q;
	logic       enterPend_q;
	logic       exitPend_q;
	logic       refPend_q;
	logic [1:0] refReq_q;
	logic [2:0] halfCnt_q;
	logic       ckRun_q;
	logic       ck_q;
	sre_pkg::sre_tmr_t tmr_q;
	sre_pkg::sre_tmr_t exitCnt_q;
	logic [2:0] mkLeft_q;
	logic [1:0] mkRate_q;
	logic [7:0] fineCnt_q;
	logic       refDone_q;
	logic       cke_q;
	logic       csN_q;
	logic       rasN_q;
	logic       casN_q;
	logic       weN_q;
	logic       odt_q;
	logic [1:0] rate_q;
	logic ckFall;
	logic tmrDone;
	logic shortReady;
	logic calReady;
	logic lockedReady;
	logic writeReady;
	logic [1:0] mode;
	logic wrCtrl;
	logic wrCmd;
	logic takeRef;
	logic takeEnter;
	sre_pkg::sre_tmr_t shortLim;
	sre_pkg::sre_tmr_t rfcSel;

	assign mode    = ctrl_q[sre_pkg::CTRL_MODE +: 2];
	assign wrCtrl  = wrStb & (addr == sre_pkg::REG_CTRL);
	assign wrCmd   = wrStb & (addr == sre_pkg::REG_CMD);
	assign ckFall  = ckRun_q & ck_q &
	                 (halfCnt_q == 3'(sre_pkg::CK_HALF - 1));
	assign tmrDone = tmr_q == '0;
	// short exit delay; abort delay when enabled
	assign shortLim = ctrl_q[sre_pkg::CTRL_ABORT] ?
	                  sre_pkg::sre_tmr_t'(sre_pkg::XSA_CYC) :
	                  sre_pkg::sre_tmr_t'(sre_pkg::XS_CYC);
	// non-locked commands wait for short delay
	assign shortReady  = exitCnt_q >= shortLim;
	assign calReady    = exitCnt_q >= sre_pkg::sre_tmr_t'(sre_pkg::XSF_CYC);
	// reads need locked delay; writes too unless reference bit set
	assign lockedReady =
		exitCnt_q >= sre_pkg::sre_tmr_t'(sre_pkg::XSDLL_CYC);
	// write wait chosen by reference bit
	assign writeReady  = ctrl_q[sre_pkg::CTRL_VREF] ? shortReady :
	                     lockedReady;
	assign takeRef   = ckFall && state_q == sre_pkg::CS_IDLE && refPend_q &&
	                   tmrDone && shortReady;
	// entry only when idle, timings met; refresh after exit
	assign takeEnter = ckFall && state_q == sre_pkg::CS_IDLE &&
	                   enterPend_q && !refPend_q && tmrDone &&
	                   shortReady && refDone_q;
	assign rfcSel = (rate_q == sre_pkg::RATE_4X) ?
	                sre_pkg::sre_tmr_t'(sre_pkg::RFC4_CYC) :
	                (rate_q == sre_pkg::RATE_2X) ?
	                sre_pkg::sre_tmr_t'(sre_pkg::RFC2_CYC) :
	                sre_pkg::sre_tmr_t'(sre_pkg::RFC1_CYC);

	assign link.ck      = ck_q;
	assign link.cke     = cke_q;
	assign link.csN     = csN_q;
	assign link.rasN    = rasN_q;
	assign link.casN    = casN_q;
	assign link.weN     = weN_q;
	assign link.actN    = 1'b1;
	assign link.odt     = odt_q;
	assign link.refRate = rate_q;

	// ==========================================================
	// Register port
	always_ff @(posedge clk) begin
		if (rst) begin
			ctrl_q      <= '0;
			enterPend_q <= 1'b0;
			exitPend_q  <= 1'b0;
			refPend_q   <= 1'b0;
			refReq_q    <= sre_pkg::RATE_1X;
		end else begin
			if (wrCtrl) begin
				ctrl_q <= wrData & sre_pkg::CTRL_RW_MASK;
			end
			if (wrCtrl && wrData[sre_pkg::CTRL_ENTER]) begin
				enterPend_q <= 1'b1;
			end else if (takeEnter) begin
				enterPend_q <= 1'b0;
			end
			if (wrCtrl && wrData[sre_pkg::CTRL_EXIT]) begin
				exitPend_q <= 1'b1;
			end else if (state_q == sre_pkg::CS_RESTART) begin
				exitPend_q <= 1'b0;
			end
			if (wrCmd && wrData[sre_pkg::CMD_REF]) begin
				refPend_q <= 1'b1;
				refReq_q  <= wrData[sre_pkg::CMD_RATE +: 2];
			end else if (takeRef) begin
				refPend_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			rdData <= '0;
		end else if (rdStb) begin
			unique case (addr)
				sre_pkg::REG_CTRL:   rdData <= ctrl_q;
				sre_pkg::REG_STATUS: rdData <= {fineCnt_q, writeReady,
				                    lockedReady, calReady, shortReady,
				                    refDone_q, state_q};
				default:             rdData <= '0;
			endcase
		end else begin
			rdData <= '0;
		end
	end

	// ==========================================================
	// Link clock divider
	always_ff @(posedge clk) begin
		if (rst || !ckRun_q) begin
			halfCnt_q <= '0;
			ck_q      <= 1'b0;
		end else if (halfCnt_q == 3'(sre_pkg::CK_HALF - 1)) begin
			halfCnt_q <= '0;
			ck_q      <= ~ck_q;
		end else begin
			halfCnt_q <= halfCnt_q + 3'h1;
		end
	end

	// ==========================================================
	// Exit timing and fine refresh count
	always_ff @(posedge clk) begin
		if (rst) begin
			exitCnt_q <= sre_pkg::sre_tmr_t'(sre_pkg::XSDLL_CYC);
		end else if (state_q == sre_pkg::CS_RESTART && tmrDone && ckFall) begin
			exitCnt_q <= '0;
		end else if (!lockedReady) begin
			exitCnt_q <= exitCnt_q + sre_pkg::sre_tmr_t'(1);
		end
	end

	// fine refresh counter; make-up ones not counted
	always_ff @(posedge clk) begin
		if (rst || (wrCtrl && wrData[sre_pkg::CTRL_MODE +: 2] != mode) ||
		    (state_q == sre_pkg::CS_EXIT && shortReady)) begin
			fineCnt_q <= '0;
		end else if (takeRef) begin
			fineCnt_q <= (refReq_q == sre_pkg::RATE_1X) ? 8'h00 :
			             fineCnt_q + 8'h01;
		end
	end

	// ==========================================================
	// Sequencer and command bus
	always_ff @(posedge clk) begin
		if (rst) begin
			state_q   <= sre_pkg::CS_IDLE;
			ckRun_q   <= 1'b1;
			tmr_q     <= '0;
			mkLeft_q  <= '0;
			mkRate_q  <= sre_pkg::RATE_1X;
			refDone_q <= 1'b1;
			cke_q     <= 1'b1;
			csN_q     <= 1'b1;
			rasN_q    <= 1'b1;
			casN_q    <= 1'b1;
			weN_q     <= 1'b1;
			odt_q     <= 1'b0;
			rate_q    <= sre_pkg::RATE_1X;
		end else begin
			if (!tmrDone) begin
				tmr_q <= tmr_q - sre_pkg::sre_tmr_t'(1);
			end
			if (ckFall) begin
				// deselect by default on each falling edge
				csN_q  <= 1'b1;
				rasN_q <= 1'b1;
				casN_q <= 1'b1;
				weN_q  <= 1'b1;
				odt_q  <= ctrl_q[sre_pkg::CTRL_ODT] & lockedReady &
				          (state_q == sre_pkg::CS_IDLE);
			end
			unique case (state_q)
				sre_pkg::CS_IDLE: begin
					if (takeEnter) begin
						cke_q  <= 1'b0;
						csN_q  <= 1'b0;
						rasN_q <= 1'b0;
						casN_q <= 1'b0;
						odt_q  <= 1'b0;
						tmr_q  <= sre_pkg::sre_tmr_t'(sre_pkg::CKSRE_CYC);
						state_q <= sre_pkg::CS_SR;
					end else if (takeRef) begin
						csN_q  <= 1'b0;
						rasN_q <= 1'b0;
						casN_q <= 1'b0;
						rate_q <= refReq_q;
						tmr_q  <= (refReq_q == sre_pkg::RATE_1X) ?
						          sre_pkg::sre_tmr_t'(sre_pkg::RFC1_CYC) :
						          sre_pkg::sre_tmr_t'(sre_pkg::RFC4_CYC);
					end
				end
				sre_pkg::CS_SR: begin
					if (tmrDone && ctrl_q[sre_pkg::CTRL_STOPCK] && ckFall) begin
						ckRun_q <= 1'b0;
					end
					if (tmrDone && exitPend_q) begin
						ckRun_q <= 1'b1;
						tmr_q   <= sre_pkg::sre_tmr_t'(sre_pkg::CKSRX_CYC);
						state_q <= sre_pkg::CS_RESTART;
					end
				end
				sre_pkg::CS_RESTART: begin
					if (tmrDone && ckFall) begin
						// CKE rises with deselect or NOP
						cke_q     <= 1'b1;
						csN_q     <= ~ctrl_q[sre_pkg::CTRL_NOPX];
						refDone_q <= 1'b0;
						state_q   <= sre_pkg::CS_EXIT;
					end
				end
				sre_pkg::CS_EXIT: begin
					if (ckFall && ctrl_q[sre_pkg::CTRL_NOPX] &&
					    exitCnt_q < sre_pkg::sre_tmr_t'(sre_pkg::MPXLH_CYC)) begin
						csN_q <= 1'b0;
					end
					if (shortReady) begin
						if (mode == sre_pkg::RATE_2X && fineCnt_q[0]) begin
							mkLeft_q <= 3'h2;
							mkRate_q <= sre_pkg::RATE_2X;
						end else if (mode == sre_pkg::RATE_4X &&
						             fineCnt_q[1:0] != 2'h0) begin
							mkLeft_q <= 3'h4;
							mkRate_q <= sre_pkg::RATE_4X;
						end else begin
							mkLeft_q <= 3'h1;
							mkRate_q <= sre_pkg::RATE_1X;
						end
						state_q <= sre_pkg::CS_MAKEUP;
					end
				end
				sre_pkg::CS_MAKEUP: begin
					if (ckFall && tmrDone) begin
						csN_q    <= 1'b0;
						rasN_q   <= 1'b0;
						casN_q   <= 1'b0;
						rate_q   <= mkRate_q;
						mkLeft_q <= mkLeft_q - 3'h1;
						state_q  <= sre_pkg::CS_MKWAIT;
					end
				end
				sre_pkg::CS_MKWAIT: begin
					tmr_q   <= rfcSel;
					state_q <= (mkLeft_q == 3'h0) ? sre_pkg::CS_IDLE :
					           sre_pkg::CS_MAKEUP;
					if (mkLeft_q == 3'h0) begin
						refDone_q <= 1'b1;
					end
				end
				default: begin
					state_q <= sre_pkg::CS_IDLE;
				end
			endcase
		end
	end
endmodule

// ### bench/sre_assertions.sv
`timescale 1ns/1ps
module sre_assertions (
	input wire logic       clk,
	input wire logic       rst,
	input wire logic       ck,
	input wire logic       cke,
	input wire logic       csN,
	input wire logic       rasN,
	input wire logic       casN,
	input wire logic       weN,
	input wire logic       actN,
	input wire logic       odt,
	input wire logic [1:0] refRate,
	input wire logic       srActive,
	input wire logic       odtEnabled,
	input wire logic       dllEnabled,
	input wire logic       dllResetPulse,
	input wire logic       vrefPowered,
	input wire logic       refreshBusy,
	input wire logic       abortEnable,
	input wire logic       vrefKeep
);
	// ==========================================================
	// Helper state
	logic               cke_q;
	logic               ck_q;
	logic               refSeen_q;
	logic [3:0]         ckIdle_q;
	logic [15:0]        lowCnt_q;
	sre_pkg::sre_tmr_t  hiCnt_q;
	logic               refCmd;
	assign refCmd = cke && !csN && !rasN && !casN && weN;
	always_ff @(posedge clk) begin
		cke_q <= rst ? 1'h1 : cke;
		ck_q  <= rst ? 1'h0 : ck;
	end
	// Cycles since the link clock last moved
	always_ff @(posedge clk) begin
		if (rst || ck != ck_q) begin
			ckIdle_q <= 4'h0;
		end else if (ckIdle_q != 4'hF) begin
			ckIdle_q <= ckIdle_q + 4'h1;
		end
	end
	always_ff @(posedge clk) begin
		lowCnt_q <= (rst || cke) ? 16'h0000 : lowCnt_q + 16'h0001;
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			hiCnt_q <= sre_pkg::sre_tmr_t'(sre_pkg::XSDLL_CYC);
		end else if (!cke) begin
			hiCnt_q <= '0;
		end else if (hiCnt_q < sre_pkg::XSDLL_CYC) begin
			hiCnt_q <= hiCnt_q + 1'h1;
		end
	end
	always_ff @(posedge clk) begin
		if (rst || refCmd) begin
			refSeen_q <= 1'h1;
		end else if (cke && !cke_q) begin
			refSeen_q <= 1'h0;
		end
	end
	// ==========================================================
	// Properties
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	sequence s_entry; $fell(cke); endsequence
	sequence s_exit; $rose(cke); endsequence
	sequence s_idle; csN || (rasN && casN && weN); endsequence
	property p_entry; s_entry |-> !csN && !rasN && !casN && weN && actN;
	endproperty
	property p_decode; s_entry |-> ##[1:16] srActive; endproperty
	property p_resid; s_exit |-> lowCnt_q >= sre_pkg::CKESR_CYC; endproperty
	property p_ckrun; s_exit |-> ckIdle_q < 4'h5; endproperty
	property p_exit; s_exit |-> s_idle; endproperty
	property p_quiet; s_exit |=> s_idle [*6]; endproperty
	property p_xs; $rose(cke) && !abortEnable |=> !refCmd [*8] ##1
		!refCmd [*5]; endproperty
	property p_ckehi; s_exit |=> cke [*8]; endproperty
	property p_odtoff; cke && hiCnt_q < sre_pkg::XSDLL_CYC - sre_pkg::NCK_CYC
		|-> !odt; endproperty
	property p_refb4; s_entry |-> refSeen_q; endproperty
	property p_odtdev; srActive && $past(srActive) |-> !odtEnabled;
	endproperty
	property p_dlldev; srActive && $past(srActive) |-> !dllEnabled;
	endproperty
	property p_dllrst; $fell(srActive) |-> ##[0:2] dllResetPulse; endproperty
	property p_vref; srActive && $past(srActive) && !vrefKeep |->
		!vrefPowered; endproperty
	property p_selfref; $rose(srActive) |-> ##[0:32] refreshBusy; endproperty
	a_entry: assert property (p_entry)
		else $error("entry command malformed");
	a_decode: assert property (p_decode)
		else $error("entry not decoded");
	a_resid: assert property (p_resid)
		else $error("residency too short");
	a_ckrun: assert property (p_ckrun)
		else $error("clock stopped at exit");
	a_exit: assert property (p_exit)
		else $error("exit without deselect");
	a_quiet: assert property (p_quiet)
		else $error("command during exit delay");
	a_xs: assert property (p_xs)
		else $error("refresh before short exit delay");
	a_ckehi: assert property (p_ckehi)
		else $error("clock enable dropped after exit");
	a_odtoff: assert property (p_odtoff)
		else $error("termination input on in locked delay");
	a_refb4: assert property (p_refb4)
		else $error("re-entry without refresh");
	a_odtdev: assert property (p_odtdev)
		else $error("termination on in self refresh");
	a_dlldev: assert property (p_dlldev)
		else $error("loop on in self refresh");
	a_dllrst: assert property (p_dllrst)
		else $error("no loop reset at exit");
	a_vref: assert property (p_vref)
		else $error("reference powered in self refresh");
	a_selfref: assert property (p_selfref)
		else $error("no internal refresh");
endmodule

// ### bench/self_refresh_entry_exit_test.sv
`timescale 1ns/1ps
module self_refresh_entry_exit_test;
	logic                   clk;
	logic                   rst;
	logic [sre_pkg::AW-1:0] addr;
	logic [sre_pkg::DW-1:0] wrData;
	logic                   wrStb;
	logic                   rdStb;
	logic [sre_pkg::DW-1:0] rdData;
	logic                   dllCfgOn;
	logic                   abortEnable;
	logic                   vrefKeep;
	logic                   srActive;
	logic                   odtEnabled;
	logic                   dllEnabled;
	logic                   dllResetPulse;
	logic                   vrefPowered;
	logic                   refreshBusy;
	logic [7:0]             refreshCount;
	logic [sre_pkg::DW-1:0] rv;
	logic [1:0]             lastRate;
	int                     errTotal;
	int                     comparisons;
	int                     refCnt;
	sre_link_if link ();
	sre_controller sre_controller_inst (.clk(clk), .rst(rst), .link(link),
		.addr(addr), .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb),
		.rdData(rdData));
	sre_device sre_device_inst (.clk(clk), .rst(rst), .link(link),
		.dllCfgOn(dllCfgOn), .abortEnable(abortEnable),
		.vrefKeep(vrefKeep), .srActive(srActive), .odtEnabled(odtEnabled),
		.dllEnabled(dllEnabled), .dllResetPulse(dllResetPulse),
		.vrefPowered(vrefPowered), .refreshBusy(refreshBusy),
		.refreshCount(refreshCount));
	sre_assertions sre_assertions_inst (.clk(clk), .rst(rst), .ck(link.ck),
		.cke(link.cke), .csN(link.csN), .rasN(link.rasN),
		.casN(link.casN), .weN(link.weN), .actN(link.actN),
		.odt(link.odt), .refRate(link.refRate), .srActive(srActive),
		.odtEnabled(odtEnabled), .dllEnabled(dllEnabled),
		.dllResetPulse(dllResetPulse), .vrefPowered(vrefPowered),
		.refreshBusy(refreshBusy), .abortEnable(abortEnable),
		.vrefKeep(vrefKeep));
	// ==========================================================
	// Refresh commands seen on the link
	always @(posedge link.ck) begin
		if (link.cke && !link.csN && !link.rasN && !link.casN && link.weN) begin
			refCnt = refCnt + 1;
			lastRate = link.refRate;
		end
	end
	// ==========================================================
	// Shared tasks
	task automatic chk(input bit ok, input string msg);
		comparisons++;
		if (!ok) begin
			$display("MISMATCH %0t %s", $time, msg);
			errTotal++;
		end
	endtask
	task automatic wr(input logic [sre_pkg::AW-1:0] a,
		input logic [sre_pkg::DW-1:0] d);
		@(posedge clk);
		addr   <= a;
		wrData <= d;
		wrStb  <= 1'h1;
		@(posedge clk);
		wrStb  <= 1'h0;
	endtask
	task automatic rd(input logic [sre_pkg::AW-1:0] a);
		@(posedge clk);
		addr  <= a;
		rdStb <= 1'h1;
		@(posedge clk);
		rdStb <= 1'h0;
		#1 rv = rdData;
	endtask
	task automatic wait_sr(input logic lvl);
		int n;
		n = 0;
		while (srActive !== lvl && n < 2000) begin
			@(posedge clk);
			n++;
		end
	endtask
	task automatic wrap_up();
		$display("Comparisons %0d, mismatches %0d", comparisons, errTotal);
		if (errTotal == 0 && comparisons > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// ==========================================================
	// Scenarios
	task automatic t_regs();
		rd(sre_pkg::REG_STATUS);
		chk(rv === 16'h00F8, "status after reset");
		wr(sre_pkg::REG_CTRL, 16'hFFFC);
		rd(sre_pkg::REG_CTRL);
		chk(rv === sre_pkg::CTRL_RW_MASK, "control readback");
		wr(4'hC, 16'hFFFF);
		rd(4'hC);
		chk(rv === 16'h0000, "unmapped read");
		wr(sre_pkg::REG_CTRL, 16'h0000);
		rd(sre_pkg::REG_CTRL);
		chk(rv === 16'h0000, "control clear");
		$display("t_regs done");
	endtask
	// Entry, residency and exit with options cw and a refresh pre
	task automatic t_sr(input logic [15:0] cw, input logic [15:0] pre,
		input int nRef);
		logic [7:0] cnt0;
		logic       ck0;
		@(posedge clk);
		abortEnable <= cw[4];
		vrefKeep    <= cw[5];
		@(negedge link.ck);
		wr(sre_pkg::REG_CTRL, cw | 16'h0001);
		if (pre != 16'h0000) begin
			wr(sre_pkg::REG_CMD, pre);
		end
		wait_sr(1'h1);
		chk(srActive === 1'h1, "no entry");
		cnt0 = refreshCount;
		repeat (100) @(posedge clk);
		#1 chk(odtEnabled === 1'h0, "termination on");
		chk(dllEnabled === 1'h0, "loop on");
		chk(vrefPowered === cw[5], "reference power");
		chk(refreshCount !== cnt0, "no internal refresh");
		if (cw[6]) begin
			ck0 = link.ck;
			repeat (16) @(posedge clk);
			chk(link.ck === ck0, "clock not stopped");
		end
		rd(sre_pkg::REG_STATUS);
		chk(rv[15:8] === {7'h00, pre[2:1] != 2'h0}, "fine count");
		refCnt = 0;
		wr(sre_pkg::REG_CTRL, cw | 16'h0002);
		wait_sr(1'h0);
		chk(srActive === 1'h0, "no exit");
		repeat (300) @(posedge clk);
		#1 chk(odtEnabled === 1'h1, "termination off");
		chk(dllEnabled === 1'h1, "loop off");
		chk(refCnt == nRef && lastRate === cw[3:2], "make-up");
		rd(sre_pkg::REG_STATUS);
		chk(rv[7:0] === {cw[5], 7'h38}, "exit readiness");
		chk(rv[15:8] === 8'h00, "fine count after exit");
		$display("t_sr done");
	endtask
	task automatic t_locked();
		repeat (sre_pkg::XSDLL_CYC) @(posedge clk);
		rd(sre_pkg::REG_STATUS);
		chk(rv[7:6] === 2'h3, "locked readiness");
		chk(link.odt === 1'h1, "termination input held");
		$display("t_locked done");
	endtask
	// ==========================================================
	// Main sequence
	initial begin
		clk = 1'h0;
		forever #10 clk = ~clk;
	end
	initial begin
		rst = 1'h1;
		addr = '0;
		wrData = '0;
		wrStb = 1'h0;
		rdStb = 1'h0;
		dllCfgOn = 1'h1;
		abortEnable = 1'h0;
		vrefKeep = 1'h1;
		errTotal = 0;
		comparisons = 0;
		refCnt = 0;
		repeat (8) @(posedge clk);
		rst <= 1'h0;
		t_regs();
		t_sr(16'h0120, 16'h0000, 1);
		t_sr(16'h0174, 16'h0003, 2);
		t_sr(16'h0188, 16'h0005, 4);
		t_locked();
		wrap_up();
	end
	initial begin
		#1000000;
		errTotal++;
		wrap_up();
	end
endmodule
